// ===== rtl/adc_timing_map.vh
// Register offsets, field positions and timing counts of the converter timing block
`ifndef ADC_TIMING_MAP_VH
`define ADC_TIMING_MAP_VH
`define OFS_CONTROL      8'h00
`define OFS_STATUS       8'h04
`define OFS_IRQ_ENABLE   8'h08
`define OFS_IRQ_CLEAR    8'h0C
`define OFS_RESULT       8'h10
`define OFS_SYSCFG       8'h14
`define OFS_CLKGEN       8'h18
`define CTL_START        0
`define CTL_POSTCAL      1
`define CTL_EIGHT_BIT    2
`define CTL_SAMPLE_LO    12
`define CTL_BCLK_LO      14
`define CTL_RESET        16'h0002
`define ST_DONE          0
`define ST_CAL_DONE      1
`define ST_BUSY          2
`define ST_CALIBRATING   3
`define CONV10_POSTCAL   8'd52
`define CONV10_PLAIN     8'd40
`define CONV8_POSTCAL    8'd44
`define CONV8_PLAIN      8'd32
`define LOAD_SYS_CYCLES  4'd6
`define CAL_MIN_BC       16'd484
`define CAL_MAX_BC       16'd11696
`define RESULT_ZERO      10'h000
`define RESULT_FULL      10'h3FF
`endif

// ===== rtl/basic_clock_div.v
// Basic clock tick generator for the converter
`timescale 1ns/1ps
`default_nettype none
module basic_clock_div (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [1:0] basic_clock_select,
    output reg        bc_tick
);
    reg  [3:0] count;
    reg  [3:0] limit;

    always @* begin
        case (basic_clock_select)
            2'b00:   limit = 4'h3;
            2'b01:   limit = 4'h1;
            2'b10:   limit = 4'hF;
            default: limit = 4'h7;
        endcase
    end

    // Ratio change applies to the current period; a count already past the new limit wraps at once
    always @(posedge aclk) begin
        if (!aresetn) begin
            count   <= 4'h0;
            bc_tick <= 1'b0;
        end else if (count >= limit) begin
            count   <= 4'h0;
            bc_tick <= 1'b1;
        end else begin
            count   <= count + 4'h1;
            bc_tick <= 1'b0;
        end
    end
endmodule // basic_clock_div
`default_nettype wire

// ===== rtl/adc_conversion_timing.v
// Converter timing, calibration and control register block
//
// Notes on behaviour
// - Field 15:14 divides system clock by 4, 2, 16 or 8.
// - Field 13:12 gives sample phase of 8, 16, 32 or 64 basic clocks.
// - 10-bit with post-calibration: 52 basic clocks plus sample plus 6.
// - No post-calibration removes 12 basic clocks from each conversion.
// - 8-bit conversion: 44 or 32 basic clocks plus sample plus 6.
// - Input below ground gives zero, above reference gives full scale.
// - After reset calibrate for 484 to 11696 basic clocks, noise dependent.
// - Conversions accepted during calibration, which then lasts longer.
// - CPU clock is master clock or half of it, by one config bit.
// - Converter runs on system clock equal to CPU clock frequency.
// - Master clock mechanism selected by a clock-generation control register.
`timescale 1ns/1ps
`default_nettype none
`include "adc_timing_map.vh"
module adc_conversion_timing #(
    parameter [15:0] CAL_BASE = 16'd484
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [9:0]  analog_code,
    input  wire        analog_below,
    input  wire        analog_above,
    input  wire [7:0]  ref_noise,
    output reg         sample_active,
    output reg         irq,
    output reg         cpu_clock_halve,
    output reg  [7:0]  master_clock_source
);
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_SAMPLE = 3'd1;
    localparam [2:0] S_CONVERT = 3'd2;
    localparam [2:0] S_LOAD = 3'd3;

    reg  [15:0] converter_control_reg;
    reg  [1:0]  status;
    reg  [1:0]  irq_enable;
    reg  [9:0]  result;
    reg  [7:0]  master_clock_source_reg;
    reg         system_config_one;
    reg  [2:0]  state;
    reg  [7:0]  bc_count;
    reg  [3:0]  sys_count;
    reg  [15:0] cal_count;
    reg  [15:0] cal_target;
    reg         calibrating;
    reg         start_req;
    reg  [7:0]  aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;
    reg  [2:0]  below_sync;
    reg  [2:0]  above_sync;
    reg  [9:0]  code_s1;
    reg  [9:0]  code_s2;
    reg  [7:0]  noise_s1;
    reg  [7:0]  noise_s2;
    wire        bc_tick;
    reg  [7:0]  sample_len;
    reg  [7:0]  conv_len;
    reg  [9:0]  next_result;
    reg  [31:0] read_word;
    reg         read_ok;
    reg         done_evt;
    reg         cal_evt;
    wire        wr_fire;
    wire [15:0] next_control;
    wire [15:0] noise_ext;

    basic_clock_div u_div (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .basic_clock_select (converter_control_reg[`CTL_BCLK_LO+1:`CTL_BCLK_LO]),
        .bc_tick            (bc_tick)
    );

    // Pins from the analog front end are asynchronous
    always @(posedge aclk) begin
        if (!aresetn) begin
            below_sync <= 3'b000;
            above_sync <= 3'b000;
            code_s1    <= 10'h000;
            code_s2    <= 10'h000;
            noise_s1   <= 8'h00;
            noise_s2   <= 8'h00;
        end else begin
            below_sync <= {below_sync[1:0], analog_below};
            above_sync <= {above_sync[1:0], analog_above};
            code_s1    <= analog_code;
            code_s2    <= code_s1;
            noise_s1   <= ref_noise;
            noise_s2   <= noise_s1;
        end
    end

    always @* begin
        case (converter_control_reg[`CTL_SAMPLE_LO+1:`CTL_SAMPLE_LO])
            2'b00:   sample_len = 8'd8;
            2'b01:   sample_len = 8'd16;
            2'b10:   sample_len = 8'd32;
            default: sample_len = 8'd64;
        endcase
        case ({converter_control_reg[`CTL_EIGHT_BIT],
               converter_control_reg[`CTL_POSTCAL]})
            2'b01:   conv_len = `CONV10_POSTCAL;
            2'b00:   conv_len = `CONV10_PLAIN;
            2'b11:   conv_len = `CONV8_POSTCAL;
            default: conv_len = `CONV8_PLAIN;
        endcase
        if (below_sync[2])
            next_result = `RESULT_ZERO;
        else if (above_sync[2])
            next_result = `RESULT_FULL;
        else
            next_result = code_s2;
    end

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign next_control = {
        w_strb[1] ? w_data[15:8] : converter_control_reg[15:8],
        w_strb[0] ? w_data[7:0]  : converter_control_reg[7:0]};
    // Noise on the reference stretches the calibration, capped at the max
    assign noise_ext = {noise_s2, 6'h00} + {8'h00, noise_s2};

    // Conversion sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state         <= S_IDLE;
            bc_count      <= 8'h00;
            sys_count     <= 4'h0;
            result        <= 10'h000;
            done_evt      <= 1'b0;
            sample_active <= 1'b0;
        end else begin
            done_evt <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_req) begin
                        state         <= S_SAMPLE;
                        bc_count      <= 8'h00;
                        sample_active <= 1'b1;
                    end
                end
                S_SAMPLE: begin
                    if (bc_tick) begin
                        if (bc_count == sample_len - 8'd1) begin
                            state         <= S_CONVERT;
                            bc_count      <= 8'h00;
                            sample_active <= 1'b0;
                        end else begin
                            bc_count <= bc_count + 8'd1;
                        end
                    end
                end
                S_CONVERT: begin
                    if (bc_tick) begin
                        if (bc_count == conv_len - 8'd1) begin
                            state     <= S_LOAD;
                            sys_count <= 4'h0;
                        end else begin
                            bc_count <= bc_count + 8'd1;
                        end
                    end
                end
                S_LOAD: begin
                    if (sys_count == `LOAD_SYS_CYCLES - 4'd1) begin
                        state    <= S_IDLE;
                        result   <= next_result;
                        done_evt <= 1'b1;
                    end else begin
                        sys_count <= sys_count + 4'd1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Reset calibration; paused while a conversion holds the converter
    always @(posedge aclk) begin
        if (!aresetn) begin
            calibrating <= 1'b1;
            cal_count   <= 16'h0000;
            cal_target  <= `CAL_MAX_BC;
            cal_evt     <= 1'b0;
        end else begin
            cal_evt <= 1'b0;
            if (cal_count == 16'h0001)
                cal_target <= (CAL_BASE + noise_ext > `CAL_MAX_BC) ?
                              `CAL_MAX_BC : CAL_BASE + noise_ext;
            if (calibrating && bc_tick && state == S_IDLE) begin
                if (cal_count >= cal_target - 16'd1) begin
                    calibrating <= 1'b0;
                    cal_evt     <= 1'b1;
                end else begin
                    cal_count <= cal_count + 16'd1;
                end
            end
        end
    end

    // Register write side
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready           <= 1'b1;
            s_axi_wready            <= 1'b1;
            s_axi_bvalid            <= 1'b0;
            s_axi_bresp             <= 2'b00;
            aw_held                 <= 1'b0;
            w_held                  <= 1'b0;
            aw_addr                 <= 8'h00;
            w_data                  <= 32'h0000_0000;
            w_strb                  <= 4'h0;
            converter_control_reg   <= `CTL_RESET;
            irq_enable              <= 2'b00;
            system_config_one       <= 1'b0;
            master_clock_source_reg <= 8'h00;
            start_req               <= 1'b0;
            status                  <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (state == S_IDLE && start_req)
                start_req <= 1'b0;
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                case (aw_addr)
                    `OFS_CONTROL: begin
                        converter_control_reg <= next_control;
                        if (w_strb[0] && w_data[`CTL_START])
                            start_req <= 1'b1;
                    end
                    `OFS_IRQ_ENABLE:
                        if (w_strb[0]) irq_enable <= w_data[1:0];
                    `OFS_SYSCFG:
                        if (w_strb[0]) system_config_one <= w_data[0];
                    `OFS_CLKGEN:
                        if (w_strb[0])
                            master_clock_source_reg <= w_data[7:0];
                    `OFS_IRQ_CLEAR: ;
                    `OFS_STATUS: ;
                    `OFS_RESULT: ;
                    default: s_axi_bresp <= 2'b10;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            // A new event outranks a clear in the same cycle
            status[`ST_DONE] <= done_evt | (status[`ST_DONE] &
                ~(wr_fire && aw_addr == `OFS_IRQ_CLEAR && w_strb[0] &&
                  w_data[`ST_DONE]));
            status[`ST_CAL_DONE] <= cal_evt | (status[`ST_CAL_DONE] &
                ~(wr_fire && aw_addr == `OFS_IRQ_CLEAR && w_strb[0] &&
                  w_data[`ST_CAL_DONE]));
        end
    end

    always @* begin
        read_ok = 1'b1;
        case (s_axi_araddr)
            `OFS_CONTROL:    read_word = {16'h0000, converter_control_reg};
            `OFS_STATUS:     read_word = {28'h0000000, calibrating,
                                          state != S_IDLE, status};
            `OFS_IRQ_ENABLE: read_word = {30'h00000000, irq_enable};
            `OFS_RESULT:     read_word = {22'h000000, result};
            `OFS_SYSCFG:     read_word = {31'h00000000, system_config_one};
            `OFS_CLKGEN:     read_word = {24'h000000, master_clock_source_reg};
            `OFS_IRQ_CLEAR:  read_word = 32'h0000_0000;
            default: begin
                read_word = 32'h0000_0000;
                read_ok   = 1'b0;
            end
        endcase
    end

    // Read side and flopped outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready       <= 1'b1;
            s_axi_rvalid        <= 1'b0;
            s_axi_rdata         <= 32'h0000_0000;
            s_axi_rresp         <= 2'b00;
            irq                 <= 1'b0;
            cpu_clock_halve     <= 1'b0;
            master_clock_source <= 8'h00;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata   <= read_word;
                s_axi_rresp   <= read_ok ? 2'b00 : 2'b10;
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            irq                 <= |(status & irq_enable);
            cpu_clock_halve     <= system_config_one;
            master_clock_source <= master_clock_source_reg;
        end
    end
endmodule // adc_conversion_timing
`default_nettype wire

// ===== tb/adc_conversion_timing_monitor.sv
// Port assertions for the converter timing block
`timescale 1ns/1ps
`default_nettype none
module adc_timing_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        sample_active,
    input wire logic        irq,
    input wire logic        cpu_clock_halve,
    input wire logic [7:0]  master_clock_source
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Cycles of the current sampling run; a tick may start mid-period
    logic [11:0] run;
    always @(posedge aclk) begin
        if (!aresetn || !sample_active) run <= 12'h000;
        else run <= run + 12'h001;
    end
    chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
        !s_axi_bvalid && !s_axi_rvalid && !irq && !sample_active)
        else $error("outputs active after reset");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    chk_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=>
        !s_axi_awready [*2]) else $error("second write taken early");
    chk_sample_long: assert property (sample_active |->
        run < 12'd1040) else $error("sampling too long");
    chk_sample_short: assert property ($fell(sample_active) |->
        run >= 12'd14) else $error("sampling too short");
    chk_no_resample: assert property ($fell(sample_active) |=>
        !sample_active [*8]) else $error("no conversion phase");
    chk_halve_cause: assert property ($changed(cpu_clock_halve) &&
        $past(aresetn) |-> $past(s_axi_bvalid))
        else $error("halve bit moved without write");
    chk_source_cause: assert property (
        $changed(master_clock_source) && $past(aresetn) |->
        $past(s_axi_bvalid)) else $error("clock source moved without write");
endmodule // adc_timing_monitor
bind adc_conversion_timing adc_timing_monitor i_adc_timing_monitor (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sample_active(sample_active), .irq(irq),
    .cpu_clock_halve(cpu_clock_halve),
    .master_clock_source(master_clock_source));
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the converter timing block
`timescale 1ns/1ps
`default_nettype none
`include "adc_timing_map.vh"
module tb;
    localparam [15:0] CAL = `CAL_MIN_BC;
    logic        aclk, aresetn, awv, wv, bre, arv, rre, below, above, was;
    logic [7:0]  aw, ar, noise;
    logic [31:0] wd;
    logic [9:0]  code;
    logic [15:0] sl, gap;
    wire         awrdy, wrdy, bv, arrdy, rv, samp, irq, halve;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  msrc;
    int          fail_count, compares, n, k, e;
    logic [33:0] rq[$];
    logic [31:0] mq[$];
    logic [1:0]  bq[$];
    adc_conversion_timing #(.CAL_BASE(CAL)) i_adc_conversion_timing (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .analog_code(code), .analog_below(below),
        .analog_above(above), .ref_noise(noise), .sample_active(samp),
        .irq(irq), .cpu_clock_halve(halve), .master_clock_source(msrc));
    initial aclk = 1'b0;
    always #2.5 aclk = ~aclk;
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task bound(input int c, input int lim);
        if (c >= lim) begin
            fail_count++;
            end_of_test;
        end
    endtask
    // Sampling length and cycles since sampling ended, kept for the checks
    always @(posedge aclk) begin
        sl <= samp ? (was ? sl + 16'h0001 : 16'h0001) : sl;
        gap <= samp ? 16'h0000 : gap + 16'h0001;
        was <= samp;
    end
    always @(posedge aclk) begin
        if (bv && bre) check(bresp, bq.pop_front());
        if (rv && rre) begin
            check({rresp, rdata & mq[0]}, rq.pop_front());
            void'(mq.pop_front());
        end
    end
    // Ready comes late at random so the response must be held
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int w;
        logic got;
        bq.push_back(r);
        w = $urandom % 4;
        @(posedge aclk);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= (w == 0);
        got = 1'b0;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awv && awrdy) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (bre && bv) begin
                bre <= 1'b0;
                got = 1'b1;
            end else if (n >= w) begin
                bre <= 1'b1;
            end
        end while (n < 300 && !got);
        bound(n, 300);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] x,
                      input logic [31:0] m);
        int w;
        logic got;
        rq.push_back(x);
        mq.push_back(m);
        w = $urandom % 3;
        @(posedge aclk);
        ar <= a;
        arv <= 1'b1;
        rre <= (w == 0);
        got = 1'b0;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arv && arrdy) arv <= 1'b0;
            if (rre && rv) begin
                rre <= 1'b0;
                got = 1'b1;
            end else if (n >= w) begin
                rre <= 1'b1;
            end
        end while (n < 300 && !got);
        bound(n, 300);
    endtask
    // Cycles stand for system clock periods; at a 40 MHz system clock
    // every select keeps the basic clock within 2.5 to 20 MHz
    task automatic convert(input logic [1:0] bs, input logic [1:0] ss,
                           input logic post, input logic eight);
        int p, t;
        logic [9:0] v;
        p = (bs == 2'b00) ? 4 : (bs == 2'b01) ? 2 : (bs == 2'b10) ? 16 : 8;
        t = eight ? (post ? 44 : 32) : (post ? 52 : 40);
        wr(`OFS_CONTROL, {16'h0, bs, ss, 9'h0, eight, post, 1'b1}, 2'b00);
        v = below ? `RESULT_ZERO : above ? `RESULT_FULL : code;
        for (n = 0; n < 4000 && !irq; n++) @(posedge aclk);
        bound(n, 4000);
        check(sl + p >= (8 << ss) * p && sl <= (8 << ss) * p + 1, 1);
        check(gap >= t * p + 5 && gap <= t * p + 9, 1);
        rd(`OFS_RESULT, {24'h0, v}, 32'h3FF);
        rd(`OFS_STATUS, 34'h1, 32'h5);
        wr(`OFS_IRQ_CLEAR, 32'h1, 2'b00);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
    endtask
    initial begin
        repeat (100000) @(posedge aclk);
        fail_count++;
        end_of_test;
    end
    initial begin
        fail_count = 0;
        compares = 0;
        {aresetn, awv, wv, bre, arv, rre, below, above} = 8'h00;
        {aw, ar, wd, code, noise} = 66'h0;
        n = $urandom(32'h4A8DE789);
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_CONTROL, {18'h0, `CTL_RESET}, 32'hFFFF);
        rd(`OFS_STATUS, 34'h8, 32'hB);
        wr(`OFS_IRQ_ENABLE, 32'h1, 2'b00);
        convert(2'b00, 2'b00, 1'b1, 1'b0);
        rd(`OFS_STATUS, 34'h8, 32'hA);
        wr(`OFS_IRQ_ENABLE, 32'h0, 2'b00);
        wr(`OFS_CONTROL, 32'h4001, 2'b00);
        // Second start lands while busy and must run after the first
        wr(`OFS_CONTROL, 32'h4001, 2'b00);
        repeat (150) @(posedge aclk);
        check(irq, 1'b0);
        rd(`OFS_STATUS, 34'h5, 32'h5);
        repeat (100) @(posedge aclk);
        wr(`OFS_IRQ_ENABLE, 32'h1, 2'b00);
        repeat (2) @(posedge aclk);
        check(irq, 1'b1);
        wr(`OFS_IRQ_CLEAR, 32'h1, 2'b00);
        k = $urandom % 256;
        wr(`OFS_SYSCFG, 32'h1, 2'b00);
        wr(`OFS_CLKGEN, k, 2'b00);
        @(posedge aclk);
        check(halve, 1'b1);
        check(msrc, k[7:0]);
        rd(`OFS_IRQ_CLEAR, 34'h0, 32'hFFFFFFFF);
        wr(8'h1C, 32'hFFFFFFFF, 2'b10);
        rd(8'h1C, {2'b10, 32'h0}, 32'h0);
        for (k = 0; k < 16; k++) begin
            code <= 10'($urandom);
            below <= ($urandom % 6) == 0;
            above <= ($urandom % 6) == 1;
            convert(k[3:2], 2'($urandom), k[0], k[1]);
        end
        noise <= 8'($urandom % 4);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        e = (CAL + 65 * noise) * 4;
        wr(`OFS_IRQ_ENABLE, 32'h2, 2'b00);
        for (n = 0; n < 5000 && !irq; n++) @(posedge aclk);
        bound(n, 5000);
        check(n + 12 >= e && n <= e + 8, 1);
        rd(`OFS_STATUS, 34'h2, 32'hA);
        end_of_test;
    end
endmodule // tb
`default_nettype wire
